// File: shared/ldc_pkg.sv
// Shared constants for the logical device configuration space
package ldc_pkg;
	localparam int LDC_DEVICES = 8;
	localparam int LDC_ADDR_W = 16;
	localparam int LDC_PIN_COUNT = 4;
	localparam int LDC_PIN_STBY = 0;
	localparam int LDC_PIN_MAIN = 1;
	localparam int LDC_PIN_HARD = 2;
	localparam int LDC_PIN_SOFT = 3;
	localparam int LDC_ADDR_LSB = 0;
	localparam int LDC_KBC_HOLD_BIT = 6;
	localparam int LDC_ACT_BIT = 0;
	localparam int LDC_STBY_KEEP_BIT = 5;

	localparam logic [7:0] LDC_IDX_LDN = 8'h07;
	localparam logic [7:0] LDC_IDX_POWER = 8'h22;
	localparam logic [7:0] LDC_IDX_CFG_LOW = 8'h26;
	localparam logic [7:0] LDC_IDX_CFG_HIGH = 8'h27;
	localparam logic [7:0] LDC_IDX_TEST_A = 8'h2B;
	localparam logic [7:0] LDC_IDX_KBC = 8'h2C;
	localparam logic [7:0] LDC_IDX_TEST_B = 8'h2D;
	localparam logic [7:0] LDC_IDX_TEST_C = 8'h2E;
	localparam logic [7:0] LDC_IDX_TEST_D = 8'h2F;
	localparam logic [7:0] LDC_IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] LDC_IDX_RSVD_FIRST = 8'h31;
	localparam logic [7:0] LDC_IDX_RSVD_LAST = 8'h5F;
	localparam logic [7:0] LDC_IDX_BASE0_HI = 8'h60;
	localparam logic [7:0] LDC_IDX_BASE0_LO = 8'h61;
	localparam logic [7:0] LDC_IDX_BASE1_HI = 8'h62;
	localparam logic [7:0] LDC_IDX_BASE1_LO = 8'h63;
	localparam logic [7:0] LDC_IDX_IRQ0 = 8'h70;
	localparam logic [7:0] LDC_IDX_IRQ1 = 8'h72;

	localparam logic [7:0] LDC_PWR_MASK = 8'h7D;
	localparam logic [15:0] LDC_CFG_DEFAULT_0 = 16'h002E;
	localparam logic [15:0] LDC_CFG_DEFAULT_1 = 16'h004E;
	localparam logic [7:0] LDC_IRQ0_LD0_RESET = 8'h06;
	localparam logic [7:0] LDC_ZERO = 8'h00;

	typedef logic [7:0] ldc_byte_t;
endpackage

// File: rtl/ldc_device_bank.sv
// One logical device bank: base address and interrupt select registers
`timescale 1ns/1ps
`default_nettype none
module ldc_device_bank
#(
	parameter ldc_pkg::ldc_byte_t IRQ0_RESET = ldc_pkg::LDC_ZERO,
	parameter bit HAS_BASE0 = 1'b1,
	parameter bit HAS_BASE1 = 1'b0,
	parameter bit HAS_IRQ1 = 1'b0
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic clear,
	input wire logic write,
	input wire ldc_pkg::ldc_byte_t index,
	input wire ldc_pkg::ldc_byte_t wdata,
	output ldc_pkg::ldc_byte_t rdata
);
	import ldc_pkg::*;

	ldc_byte_t base0_hi;
	ldc_byte_t base0_lo;
	ldc_byte_t base1_hi;
	ldc_byte_t base1_lo;
	ldc_byte_t irq0;
	ldc_byte_t irq1;

	always_ff @(posedge clk)
	begin
		if (reset || clear)
		begin
			base0_hi <= LDC_ZERO; // R12
			base0_lo <= LDC_ZERO;
			base1_hi <= LDC_ZERO;
			base1_lo <= LDC_ZERO;
		end
		else if (write)
		begin
			// Unused base registers simply never latch
			if (HAS_BASE0 && index == LDC_IDX_BASE0_HI) base0_hi <= wdata; // R12 R13
			if (HAS_BASE0 && index == LDC_IDX_BASE0_LO) base0_lo <= wdata; // R12 R13
			if (HAS_BASE1 && index == LDC_IDX_BASE1_HI) base1_hi <= wdata; // R12 R13
			if (HAS_BASE1 && index == LDC_IDX_BASE1_LO) base1_lo <= wdata; // R12 R13
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset || clear)
		begin
			irq0 <= IRQ0_RESET; // R15
			irq1 <= LDC_ZERO;
		end
		else if (write)
		begin
			if (index == LDC_IDX_IRQ0) irq0 <= wdata; // R14
			if (HAS_IRQ1 && index == LDC_IDX_IRQ1) irq1 <= wdata; // R14
		end
	end

	always_comb
	begin
		case (index)
			LDC_IDX_BASE0_HI: rdata = HAS_BASE0 ? base0_hi : LDC_ZERO; // R13 R18
			LDC_IDX_BASE0_LO: rdata = HAS_BASE0 ? base0_lo : LDC_ZERO; // R13 R18
			LDC_IDX_BASE1_HI: rdata = HAS_BASE1 ? base1_hi : LDC_ZERO; // R13 R18
			LDC_IDX_BASE1_LO: rdata = HAS_BASE1 ? base1_lo : LDC_ZERO; // R13 R18
			LDC_IDX_IRQ0: rdata = irq0; // R18
			LDC_IDX_IRQ1: rdata = HAS_IRQ1 ? irq1 : LDC_ZERO; // R14
			default: rdata = LDC_ZERO;
		endcase
	end

	default clocking bank_cb @(posedge clk); endclocking
	default disable iff (reset);

	irq_reset_a: assert property (clear |=> irq0 == IRQ0_RESET) // R15
		else $error("interrupt select reset value wrong");
	irq1_unused_a: assert property (!HAS_IRQ1 |-> rdata == LDC_ZERO || index != LDC_IDX_IRQ1) // R14
		else $error("unused second interrupt select not zero");
	base_store_a: assert property (write && !clear && HAS_BASE0 && index == LDC_IDX_BASE0_HI
		|=> base0_hi == $past(wdata)) // R12
		else $error("base address high byte not stored");
	base_unused_a: assert property (!HAS_BASE1 && (index == LDC_IDX_BASE1_HI
		|| index == LDC_IDX_BASE1_LO) |-> rdata == LDC_ZERO) // R13
		else $error("unused base address not zero");
endmodule
`default_nettype wire

// File: rtl/ldc_config_space.sv
// Configuration register space: index/data port, chip registers, device banks
// Notes on behaviour
// R1 - Test registers clear on both power-on resets
// R2 - Bit 6 of 0x2C holds keyboard controller reset
// R3 - Configuration port address always even
// R4 - Low byte first; high byte write moves port
// R5 - Port address default from strap, hard/main reset
// R6 - Power bit 5 cleared by standby reset only
// R7 - Eight banks, chosen by device number register
// R8 - Index port selects, data port accesses register
// R9 - No response outside configuration state
// R10 - Activate bit 0, reserved zero, resets always except device 5 (standby reset only)
// R11 - Indices 0x31 to 0x5F read zero
// R12 - Base address bytes at 0x60-0x63, reset zero
// R13 - Unused base registers ignore writes, read zero
// R14 - 0x70 everywhere; 0x72 only keyboard controller
// R15 - Primary interrupt select resets 0x06 device zero
// R16 - Activate and power bits linked, except devices 1 and 7 which have no power bit
// R17 - Device number write selects current device
// R18 - Implemented registers read back last write
`timescale 1ns/1ps
`default_nettype none
module ldc_config_space
#(
	parameter int KBC_LDN = 7,
	parameter logic [7:0] BASE0_MASK = 8'hFF,
	parameter logic [7:0] BASE1_MASK = 8'h00
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic standby_power_on_reset,
	input wire logic main_power_on_reset,
	input wire logic hard_reset,
	input wire logic soft_reset,
	input wire logic config_strap,
	input wire logic config_mode,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [ldc_pkg::LDC_ADDR_W-1:0] io_addr,
	input wire ldc_pkg::ldc_byte_t io_wdata,
	output ldc_pkg::ldc_byte_t io_rdata,
	output logic io_ack,
	output logic [ldc_pkg::LDC_ADDR_W-1:0] config_base,
	output logic kbc_hold,
	output logic [ldc_pkg::LDC_DEVICES-1:0] device_on
);
	import ldc_pkg::*;

	logic [LDC_PIN_COUNT-1:0] pin_meta;
	logic [LDC_PIN_COUNT-1:0] pin_sync;
	logic strap_meta;
	logic strap_sync;
	logic cfg_load_pending;
	ldc_byte_t cur_index;
	ldc_byte_t ldn;
	ldc_byte_t cfg_low;
	ldc_byte_t cfg_high;
	ldc_byte_t test_a;
	ldc_byte_t test_kbc;
	ldc_byte_t test_b;
	ldc_byte_t test_c;
	ldc_byte_t test_d;
	logic [LDC_DEVICES-1:0] dev_act;
	ldc_byte_t bank_rd [LDC_DEVICES];
	ldc_byte_t read_value;

	wire logic clr_test = pin_sync[LDC_PIN_MAIN] | pin_sync[LDC_PIN_STBY];
	wire logic clr_cfgaddr = pin_sync[LDC_PIN_MAIN] | pin_sync[LDC_PIN_HARD];
	wire logic clr_all = |pin_sync;
	wire logic clr_keep = pin_sync[LDC_PIN_STBY];
	wire logic [LDC_ADDR_W-1:0] data_addr = {config_base[LDC_ADDR_W-1:1], 1'b1};
	wire logic hit_index = config_mode && io_addr == config_base;
	wire logic hit_data = config_mode && io_addr == data_addr;
	wire logic wr_index = io_wr && hit_index;
	wire logic wr_data = io_wr && hit_data;
	wire logic ldn_valid = ldn < 8'(LDC_DEVICES);
	wire logic [2:0] ldn_sel = ldn[2:0];
	wire logic wr_act = wr_data && cur_index == LDC_IDX_ACTIVATE;
	wire logic wr_pwr = wr_data && cur_index == LDC_IDX_POWER;
	wire logic [LDC_ADDR_W-1:0] strap_default = strap_sync ? LDC_CFG_DEFAULT_1 : LDC_CFG_DEFAULT_0;

	// Reset pins arrive from outside the clock domain
	always_ff @(posedge clk)
	begin
		// Strap stage runs through reset so the first load after release sees the pin
		strap_meta <= config_strap;
		strap_sync <= strap_meta;
		if (reset)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
		end
		else
		begin
			pin_meta <= {soft_reset, hard_reset, main_power_on_reset, standby_power_on_reset};
			pin_sync <= pin_meta;
		end
	end

	// Strap is sampled after release; the port sits at the low default meanwhile
	always_ff @(posedge clk)
	begin
		if (reset)
			cfg_load_pending <= 1'b1;
		else
			cfg_load_pending <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			config_base <= LDC_CFG_DEFAULT_0;
			cfg_low <= LDC_CFG_DEFAULT_0[7:0];
			cfg_high <= LDC_CFG_DEFAULT_0[15:8];
		end
		else if (cfg_load_pending || clr_cfgaddr)
		begin
			config_base <= strap_default; // R5
			cfg_low <= strap_default[7:0];
			cfg_high <= strap_default[15:8];
		end
		else if (wr_data && cur_index == LDC_IDX_CFG_LOW)
			cfg_low <= {io_wdata[7:1], 1'b0}; // R3 R4
		else if (wr_data && cur_index == LDC_IDX_CFG_HIGH)
		begin
			// Port moves on this edge; the next access must use the new address
			cfg_high <= io_wdata;
			config_base <= {io_wdata, cfg_low}; // R4
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset || clr_all)
			cur_index <= LDC_ZERO;
		else if (wr_index)
			cur_index <= io_wdata; // R8
	end

	always_ff @(posedge clk)
	begin
		if (reset || clr_all)
			ldn <= LDC_ZERO;
		else if (wr_data && cur_index == LDC_IDX_LDN)
			ldn <= io_wdata; // R17
	end

	always_ff @(posedge clk)
	begin
		if (reset || clr_test)
		begin
			test_a <= LDC_ZERO; // R1
			test_kbc <= LDC_ZERO; // R2
			test_b <= LDC_ZERO;
			test_c <= LDC_ZERO;
			test_d <= LDC_ZERO;
		end
		else if (wr_data)
		begin
			if (cur_index == LDC_IDX_TEST_A) test_a <= io_wdata;
			if (cur_index == LDC_IDX_KBC) test_kbc <= io_wdata;
			if (cur_index == LDC_IDX_TEST_B) test_b <= io_wdata;
			if (cur_index == LDC_IDX_TEST_C) test_c <= io_wdata;
			if (cur_index == LDC_IDX_TEST_D) test_d <= io_wdata;
		end
	end

	// One storage bit per device serves the activate view and, except for devices 1 and 7, the power view
	for (genvar b = 0; b < LDC_DEVICES; b++)
	begin : g_act
		wire logic clr_b = (b == LDC_STBY_KEEP_BIT) ? clr_keep : clr_all;
		always_ff @(posedge clk)
		begin
			if (reset || clr_b)
				dev_act[b] <= 1'b0; // R6 R10
			else if (wr_act && ldn == 8'(b))
				dev_act[b] <= io_wdata[LDC_ACT_BIT]; // R10 R16 R17
			else if (wr_pwr && LDC_PWR_MASK[b])
				dev_act[b] <= io_wdata[b]; // R16
		end
	end

	for (genvar d = 0; d < LDC_DEVICES; d++)
	begin : g_bank
		ldc_device_bank
		#(
			.IRQ0_RESET((d == 0) ? LDC_IRQ0_LD0_RESET : LDC_ZERO),
			.HAS_BASE0(BASE0_MASK[d]),
			.HAS_BASE1(BASE1_MASK[d]),
			.HAS_IRQ1(d == KBC_LDN)
		)
		u_bank
		(
			.clk(clk),
			.reset(reset),
			.clear(clr_all),
			.write(wr_data && ldn == 8'(d)), // R7
			.index(cur_index),
			.wdata(io_wdata),
			.rdata(bank_rd[d])
		);
	end

	always_comb
	begin
		read_value = LDC_ZERO;
		case (cur_index)
			LDC_IDX_LDN: read_value = ldn;
			LDC_IDX_POWER: read_value = dev_act & LDC_PWR_MASK; // R16
			LDC_IDX_CFG_LOW: read_value = cfg_low; // R18
			LDC_IDX_CFG_HIGH: read_value = cfg_high; // R18
			LDC_IDX_TEST_A: read_value = test_a;
			LDC_IDX_KBC: read_value = test_kbc;
			LDC_IDX_TEST_B: read_value = test_b;
			LDC_IDX_TEST_C: read_value = test_c;
			LDC_IDX_TEST_D: read_value = test_d;
			LDC_IDX_ACTIVATE: read_value = ldn_valid ? {7'h00, dev_act[ldn_sel]} : LDC_ZERO; // R10
			default:
			begin
				if (cur_index > LDC_IDX_RSVD_LAST && ldn_valid)
					read_value = bank_rd[ldn_sel]; // R7
				else
					read_value = LDC_ZERO; // R11
			end
		endcase
	end

	// Answer one cycle after the access; silent outside configuration state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			io_ack <= 1'b0;
			io_rdata <= LDC_ZERO;
		end
		else
		begin
			io_ack <= (io_rd || io_wr) && (hit_index || hit_data); // R9
			if (io_rd && hit_index)
				io_rdata <= cur_index; // R8
			else if (io_rd && hit_data)
				io_rdata <= read_value; // R8
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			kbc_hold <= 1'b0;
			device_on <= '0;
		end
		else
		begin
			kbc_hold <= test_kbc[LDC_KBC_HOLD_BIT]; // R2
			device_on <= dev_act; // R16
		end
	end

	default clocking cfg_cb @(posedge clk); endclocking
	default disable iff (reset);

	test_clear_a: assert property (clr_test |=> test_a == LDC_ZERO && test_d == LDC_ZERO) // R1
		else $error("test registers not cleared");
	kbc_hold_a: assert property (wr_data && cur_index == LDC_IDX_KBC && !clr_test
		|=> ##1 kbc_hold == $past(io_wdata[LDC_KBC_HOLD_BIT], 2)) // R2
		else $error("keyboard hold does not follow bit 6");
	cfg_move_a: assert property (wr_data && cur_index == LDC_IDX_CFG_HIGH && !clr_cfgaddr
		&& !cfg_load_pending |=> config_base == {$past(io_wdata), $past(cfg_low)}) // R4
		else $error("configuration port did not move");
	cfg_low_hold_a: assert property (wr_data && cur_index == LDC_IDX_CFG_LOW && !clr_cfgaddr
		&& !cfg_load_pending |=> $stable(config_base) && !config_base[LDC_ADDR_LSB]) // R4
		else $error("low byte write moved the port");
	cfg_default_a: assert property (clr_cfgaddr |=> config_base
		== ($past(strap_sync) ? LDC_CFG_DEFAULT_1 : LDC_CFG_DEFAULT_0)) // R5
		else $error("configuration default wrong");
	keep_bit_a: assert property (clr_all && !clr_keep && !wr_data
		|=> dev_act[LDC_STBY_KEEP_BIT] == $past(dev_act[LDC_STBY_KEEP_BIT])) // R6
		else $error("power bit 5 lost on other reset");
	act_read_a: assert property (io_rd && hit_data && cur_index == LDC_IDX_ACTIVATE && ldn_valid
		|=> io_rdata == {7'h00, $past(dev_act[ldn_sel])}) // R10
		else $error("activate read wrong");
	no_resp_a: assert property (!config_mode |=> !io_ack) // R9
		else $error("answered outside configuration state");
	rsvd_zero_a: assert property (io_rd && hit_data && cur_index >= LDC_IDX_RSVD_FIRST
		&& cur_index <= LDC_IDX_RSVD_LAST |=> io_rdata == LDC_ZERO) // R11
		else $error("reserved index not zero");
	link_a: assert property (wr_act && ldn == LDC_ZERO && !clr_all
		|=> (dev_act & LDC_PWR_MASK) == ($past(dev_act & LDC_PWR_MASK) & 8'hFE
		| {7'h00, $past(io_wdata[LDC_ACT_BIT])})) // R16
		else $error("activate and power bits not linked");

	move_c: cover property (wr_data && cur_index == LDC_IDX_CFG_HIGH ##1 io_wr && hit_index);
	hold_c: cover property ($rose(kbc_hold));
	bank_c: cover property (wr_data && cur_index == LDC_IDX_IRQ1 && ldn == 8'(KBC_LDN));
endmodule
`default_nettype wire

// File: testbench/ldc_host_model.sv
// Host model issuing index and data port accesses
`timescale 1ns/1ps
`default_nettype none
module ldc_host_model
(
	input wire logic clk,
	input wire logic io_ack,
	input wire ldc_pkg::ldc_byte_t io_rdata,
	output logic io_rd,
	output logic io_wr,
	output logic [15:0] io_addr,
	output ldc_pkg::ldc_byte_t io_wdata
);
	import ldc_pkg::*;
	logic [15:0] port = 16'h002E;
	bit acked;
	ldc_byte_t seen;
	initial
	begin
		io_rd = 1'b0;
		io_wr = 1'b0;
		io_addr = 16'h0000;
		io_wdata = 8'h00;
	end
	// One strobe cycle; answer is looked at in the cycle after
	task automatic access(input bit rd, input bit data, input ldc_byte_t v);
		@(negedge clk);
		io_addr = port | 16'(data);
		io_wdata = v;
		io_rd = rd;
		io_wr = !rd;
		@(negedge clk);
		io_rd = 1'b0;
		io_wr = 1'b0;
		acked = (io_ack === 1'b1);
		seen = io_rdata;
		// Released lines never keep the last value
		io_addr = ~io_addr;
		io_wdata = ~io_wdata;
	endtask
	task automatic put(input ldc_byte_t idx, input ldc_byte_t v);
		access(1'b0, 1'b0, idx);
		access(1'b0, 1'b1, v);
	endtask
	task automatic get(input ldc_byte_t idx);
		access(1'b0, 1'b0, idx);
		access(1'b1, 1'b1, 8'h00);
	endtask
endmodule
`default_nettype wire

// File: testbench/logical_device_config_space_tb_top.sv
// Self-checking bench for the configuration register space
`timescale 1ns/1ps
`default_nettype none
module logical_device_config_space_tb_top;
	import ldc_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] pins = 4'h0;
	logic strap = 1'b0;
	logic mode = 1'b1;
	logic io_rd;
	logic io_wr;
	logic io_ack;
	logic kbc_hold;
	logic [15:0] io_addr;
	logic [15:0] config_base;
	logic [7:0] device_on;
	ldc_byte_t io_wdata;
	ldc_byte_t io_rdata;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	ldc_config_space uut
	(
		.clk(clk), .reset(reset),
		.standby_power_on_reset(pins[LDC_PIN_STBY]), .main_power_on_reset(pins[LDC_PIN_MAIN]),
		.hard_reset(pins[LDC_PIN_HARD]), .soft_reset(pins[LDC_PIN_SOFT]),
		.config_strap(strap), .config_mode(mode), .io_rd(io_rd), .io_wr(io_wr),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
		.config_base(config_base), .kbc_hold(kbc_hold), .device_on(device_on)
	);
	ldc_host_model host
	(
		.clk(clk), .io_ack(io_ack), .io_rdata(io_rdata), .io_rd(io_rd),
		.io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata)
	);
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask
	task automatic wr(input ldc_byte_t idx, input ldc_byte_t v);
		host.put(idx, v);
		check("write ack", 16'h0001, {15'h0000, host.acked});
	endtask
	task automatic rd(input ldc_byte_t idx, input ldc_byte_t exp);
		host.get(idx);
		check("read ack", 16'h0001, {15'h0000, host.acked});
		check($sformatf("index %h", idx), {8'h00, exp}, {8'h00, host.seen});
	endtask
	// Pulse long enough to pass the pin synchroniser
	task automatic pin_reset(input int p);
		@(negedge clk);
		pins[p] = 1'b1;
		repeat (4) @(negedge clk);
		pins[p] = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			failures++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (5) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		check("config_base", 16'h002E, config_base);
		for (int i = 0; i < 5; i++)
			rd(LDC_IDX_TEST_A + 8'(i), 8'h00);
		for (int i = 0; i < 5; i++)
			wr(LDC_IDX_TEST_A + 8'(i), 8'h81 + 8'(i));
		for (int i = 0; i < 5; i++)
			rd(LDC_IDX_TEST_A + 8'(i), 8'h81 + 8'(i));
		wr(LDC_IDX_KBC, 8'h40);
		repeat (2) @(negedge clk);
		check("kbc_hold", 16'h0001, {15'h0000, kbc_hold});
		wr(LDC_IDX_KBC, 8'h00);
		repeat (2) @(negedge clk);
		check("kbc_hold", 16'h0000, {15'h0000, kbc_hold});
		for (int n = 0; n < 8; n++)
		begin
			wr(LDC_IDX_LDN, 8'(n));
			rd(LDC_IDX_IRQ0, (n == 0) ? 8'h06 : 8'h00);
			wr(LDC_IDX_BASE0_HI, 8'h10 + 8'(n));
			wr(LDC_IDX_BASE0_LO, 8'hA0 + 8'(n));
			wr(LDC_IDX_IRQ0, 8'h03 + 8'(n));
			wr(LDC_IDX_IRQ1, 8'h55);
			wr(LDC_IDX_BASE1_HI, 8'hFF);
			wr(LDC_IDX_RSVD_FIRST, 8'hFF);
			wr(LDC_IDX_RSVD_LAST, 8'hFF);
		end
		for (int n = 0; n < 8; n++)
		begin
			wr(LDC_IDX_LDN, 8'(n));
			rd(LDC_IDX_BASE0_HI, 8'h10 + 8'(n));
			rd(LDC_IDX_BASE0_LO, 8'hA0 + 8'(n));
			rd(LDC_IDX_IRQ0, 8'h03 + 8'(n));
			rd(LDC_IDX_IRQ1, (n == 7) ? 8'h55 : 8'h00);
			rd(LDC_IDX_BASE1_HI, 8'h00);
			rd(LDC_IDX_RSVD_FIRST, 8'h00);
			rd(LDC_IDX_RSVD_LAST, 8'h00);
		end
		wr(LDC_IDX_LDN, 8'h02);
		host.access(1'b1, 1'b0, 8'h00);
		check("index ack", 16'h0001, {15'h0000, host.acked});
		check("index port", {8'h00, LDC_IDX_LDN}, {8'h00, host.seen});
		wr(LDC_IDX_ACTIVATE, 8'hFF);
		rd(LDC_IDX_ACTIVATE, 8'h01);
		check("device_on", 16'h0004, {8'h00, device_on});
		rd(LDC_IDX_POWER, 8'h04);
		wr(LDC_IDX_POWER, 8'h00);
		rd(LDC_IDX_ACTIVATE, 8'h00);
		check("device_on", 16'h0000, {8'h00, device_on});
		wr(LDC_IDX_LDN, 8'h00);
		wr(LDC_IDX_ACTIVATE, 8'h01);
		rd(LDC_IDX_POWER, 8'h01);
		check("device_on", 16'h0001, {8'h00, device_on});
		wr(LDC_IDX_LDN, 8'h05);
		wr(LDC_IDX_ACTIVATE, 8'h01);
		wr(LDC_IDX_LDN, 8'h03);
		wr(LDC_IDX_ACTIVATE, 8'h01);
		pin_reset(LDC_PIN_HARD);
		check("device_on", 16'h0020, {8'h00, device_on});
		rd(LDC_IDX_TEST_A, 8'h81);
		pin_reset(LDC_PIN_STBY);
		check("device_on", 16'h0000, {8'h00, device_on});
		rd(LDC_IDX_TEST_A, 8'h00);
		wr(LDC_IDX_CFG_LOW, 8'h51);
		check("config_base", 16'h002E, config_base);
		wr(LDC_IDX_CFG_HIGH, 8'h12);
		check("config_base", 16'h1250, config_base);
		host.port = 16'h1250;
		rd(LDC_IDX_CFG_LOW, 8'h50);
		rd(LDC_IDX_CFG_HIGH, 8'h12);
		pin_reset(LDC_PIN_SOFT);
		check("config_base", 16'h1250, config_base);
		wr(LDC_IDX_TEST_A, 8'h7E);
		strap = 1'b1;
		repeat (4) @(negedge clk);
		pin_reset(LDC_PIN_MAIN);
		check("config_base", 16'h004E, config_base);
		host.port = 16'h004E;
		rd(LDC_IDX_TEST_A, 8'h00);
		mode = 1'b0;
		host.put(LDC_IDX_TEST_A, 8'h3C);
		check("refused ack", 16'h0000, {15'h0000, host.acked});
		mode = 1'b1;
		rd(LDC_IDX_TEST_A, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
